// file: include/cgl_defines.vh
`ifndef CGL_DEFINES_VH
`define CGL_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CGL_OFF_PICK        12'h000
`define CGL_OFF_LINE_CFG    12'h004
`define CGL_OFF_SPAN        12'h008
`define CGL_OFF_LEVEL       12'h00C
`define CGL_OFF_LEVELS      12'h010
`define CGL_OFF_SOFT_PICK   12'h014
`define CGL_OFF_SOFT_VALUE  12'h018
`define CGL_OFF_SOFT_PACKED 12'h01C
`define CGL_OFF_CIRCUIT     12'h020

// ----------------------------------------
// Line configuration fields
// ----------------------------------------
`define CGL_CFG_DIR         0
`define CGL_CFG_FLIP        1
`define CGL_CFG_AUX         2
`define CGL_CFG_KIND        3
`define CGL_CFG_SRC_LO      8
`define CGL_CFG_SRC_HI      11

// ----------------------------------------
// Output source codes
// ----------------------------------------
`define CGL_SRC_OFF         4'h0
`define CGL_SRC_LINE0       4'h1
`define CGL_SRC_SOFT0       4'h5
`define CGL_SRC_CNT0        4'h9
`define CGL_SRC_CNT1        4'hA
`define CGL_SRC_LB0         4'hB
`define CGL_SRC_LB1         4'hC
`define CGL_SRC_EXPO        4'hD
`define CGL_SRC_FTW         4'hE

// ----------------------------------------
// Circuit type codes
// ----------------------------------------
`define CGL_FMT_TRISTATE    3'h1
`define CGL_FMT_OPTO        3'h5
`define CGL_FMT_OPENDRAIN   3'h6

// ----------------------------------------
// Timing
// ----------------------------------------
`define CGL_CLK_MHZ         24'h19
`define CGL_SPAN_W          16
`define CGL_CNT_W           24

`endif

// file: verification/cgl_ext_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Circuits on the connector
// ------------------------------
module cgl_ext_model (
    // Block pin side
    input wire logic [3:0] line_out,
    input wire logic [3:0] line_oe,
    // Levels the external circuits apply
    input wire logic [3:0] ext_level,
    // Resolved wire levels
    output var logic [3:0] line_in
);
    // A driven pin wins; an undriven line follows the external level
    always_comb line_in = (line_oe & line_out) | (~line_oe & ext_level);
endmodule // cgl_ext_model
`default_nettype wire

// file: verification/cgl_gpio_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Port checker
// ------------------------------
module cgl_gpio_chk (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // Register bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins
    input wire logic [3:0]  line_out,
    input wire logic [3:0]  line_oe
);
    // One domain, so one default clock and reset
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("ready not after one wait state");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_ready_cause: assert property (pready |-> $past(psel) && $past(penable))
        else $error("ready without access");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_unmapped_err: assert property (psel && penable && !pready
        && paddr[11:2] > 10'h008 |=> pslverr)
        else $error("unmapped access not refused");
    a_fixed_inputs: assert property (!line_oe[0] && !line_oe[3])
        else $error("input-only line driven");
    a_quiet_input: assert property ((line_out & ~line_oe) == 4'h0)
        else $error("data on undriven line");
endmodule // cgl_gpio_chk

bind cgl_gpio cgl_gpio_chk i_cgl_gpio_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_out(line_out), .line_oe(line_oe)
);
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "cgl_defines.vh"
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    logic [3:0]  ext;      // External levels
    logic [5:0]  src_in;   // Internal sources, code 9 first
    logic        er;
    wire  [31:0] prdata;
    wire  [3:0]  line_in, line_out, line_oe, line_level;
    wire         pready, pslverr, aux_supply_on;
    int          n_fail, samples_checked, i;

    cgl_gpio i_cgl_gpio (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .line_in(line_in), .line_out(line_out), .line_oe(line_oe),
        .aux_supply_on(aux_supply_on), .counter_active(src_in[1:0]),
        .logic_block(src_in[3:2]), .exposure_active(src_in[4]),
        .frame_trigger_wait(src_in[5]), .line_level(line_level));
    cgl_ext_model i_cgl_ext_model (.line_out(line_out), .line_oe(line_oe),
        .ext_level(ext), .line_in(line_in));

    // ------------------------------
    // Clock and bus tasks
    // ------------------------------
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic tally_and_finish();
        if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One transfer; an idle edge first keeps drivers single per step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_fail++;
            $display("[ERR] %0t bus hang", $time);
            tally_and_finish();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // ------------------------------
    // Scenarios
    // ------------------------------
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, ext, src_in} = '0;
        n_fail = 0;
        samples_checked = 0;
        cyc(5);
        presetn <= 1'b1;
        rdc(`CGL_OFF_PICK, 32'h0);
        rdc(`CGL_OFF_CIRCUIT, {29'h0, `CGL_FMT_OPTO});
        wr(`CGL_OFF_PICK, 32'h3);
        rdc(`CGL_OFF_CIRCUIT, {29'h0, `CGL_FMT_TRISTATE});
        wr(`CGL_OFF_LINE_CFG, 32'h5);
        rdc(`CGL_OFF_LINE_CFG, 32'h0);
        apb(1'b0, 12'h024, 32'h0);
        chk({31'h0, er}, 32'h1);
        // Levels of the input lines, then with line 3 inverted
        ext <= 4'hA;
        cyc(4);
        rdc(`CGL_OFF_LEVELS, 32'hA);
        rdc(`CGL_OFF_LEVEL, 32'h1);
        wr(`CGL_OFF_LINE_CFG, 32'h2);
        rdc(`CGL_OFF_LEVELS, 32'h2);
        wr(`CGL_OFF_LINE_CFG, 32'h0);
        // Line 1 drives user bits
        wr(`CGL_OFF_PICK, 32'h1);
        wr(`CGL_OFF_LINE_CFG, 32'h501);
        wr(`CGL_OFF_SOFT_PICK, 32'h0);
        wr(`CGL_OFF_SOFT_VALUE, 32'h1);
        cyc(2);
        chk({30'h0, line_oe[1], line_out[1]}, 32'h3);
        wr(`CGL_OFF_SOFT_PACKED, 32'hA);
        rdc(`CGL_OFF_SOFT_PACKED, 32'hA);
        chk({31'h0, line_out[1]}, 32'h0);
        wr(`CGL_OFF_SOFT_PICK, 32'h2);
        wr(`CGL_OFF_SOFT_VALUE, 32'h1);
        rdc(`CGL_OFF_SOFT_PICK, 32'h2);
        rdc(`CGL_OFF_SOFT_VALUE, 32'h1);
        rdc(`CGL_OFF_SOFT_PACKED, 32'hE);
        wr(`CGL_OFF_LINE_CFG, 32'h603);
        cyc(2);
        chk({31'h0, line_out[1]}, 32'h0);
        // Every internal source, one hot at a time
        for (i = 0; i < 6; i++) begin
            src_in <= 6'h1 << i;
            wr(`CGL_OFF_LINE_CFG, {20'h0, 4'h9 + 4'(i), 8'h01});
            cyc(2);
            chk({31'h0, line_out[1]}, 32'h1);
        end
        wr(`CGL_OFF_LINE_CFG, 32'h401);
        ext <= 4'h0;
        cyc(5);
        chk({31'h0, line_out[1]}, 32'h0);
        ext <= 4'h8;
        cyc(5);
        chk({31'h0, line_out[1]}, 32'h1);
        wr(`CGL_OFF_LINE_CFG, 32'h400);
        cyc(2);
        chk({30'h0, line_oe[1], line_out[1]}, 32'h0);
        // Line 2 open drain with the supply on
        src_in <= 6'h10;
        wr(`CGL_OFF_PICK, 32'h2);
        wr(`CGL_OFF_LINE_CFG, 32'hD05);
        rdc(`CGL_OFF_CIRCUIT, {29'h0, `CGL_FMT_OPENDRAIN});
        chk({30'h0, aux_supply_on, line_out[2]}, 32'h3);
        // Deglitch of 1 us, i.e. 25 cycles
        // Timing is judged on the level pins; a status poll is too coarse
        ext <= 4'h0;
        wr(`CGL_OFF_PICK, 32'h0);
        wr(`CGL_OFF_LINE_CFG, 32'h0);
        wr(`CGL_OFF_SPAN, 32'h1);
        ext <= 4'h1;
        cyc(10);
        ext <= 4'h0;
        cyc(30);
        chk({31'h0, line_level[0]}, 32'h0);
        ext <= 4'h1;
        cyc(15);
        chk({31'h0, line_level[0]}, 32'h0);
        cyc(20);
        chk({31'h0, line_level[0]}, 32'h1);
        // Debounce after a zero-width deglitch
        wr(`CGL_OFF_SPAN, 32'h0);
        wr(`CGL_OFF_LINE_CFG, 32'h8);
        wr(`CGL_OFF_SPAN, 32'h1);
        ext <= 4'h0;
        cyc(4);
        chk({31'h0, line_level[0]}, 32'h0);
        ext <= 4'h1;
        cyc(4);
        chk({31'h0, line_level[0]}, 32'h0);
        cyc(30);
        chk({31'h0, line_level[0]}, 32'h1);
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire

// file: verilog/cgl_gpio.v
// Behaviour
// - Four lines, selector picks configured line
// - Per-line direction input or output; lines 0 and 3 input only
// - Per-line inverter flips logic sense
// - Selected line status reads one when high
// - Packed status word, bit n is line n
// - Per-line deglitch and debounce widths in us
// - Deglitch changes after level held full width
// - Debounce passes first edge, then holds
// - Deglitch feeds debounce
// - Output source selector, lines give loopback
// - Sources: user, counter, logic, exposure, trigger-wait
// - Single value write sets picked user bit
// - Packed user word writes and reads all
// - Read-only circuit type per line
// - Line 3 is non-isolated input only
// - Line 2 bidirectional with 3.3 V option
// - Supply enable only on capable lines
`timescale 1ns/1ps
`default_nettype none
`include "cgl_defines.vh"

module cgl_gpio (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Connector lines
    input  wire [3:0]  line_in,
    output reg  [3:0]  line_out,
    output reg  [3:0]  line_oe,
    output reg         aux_supply_on,
    // Internal sources
    input  wire [1:0]  counter_active,
    input  wire [1:0]  logic_block,
    input  wire        exposure_active,
    input  wire        frame_trigger_wait,
    // Filtered levels for internal consumers
    output reg  [3:0]  line_level
);

    // ----------------------------------------
    // Configuration state
    // ----------------------------------------
    reg  [1:0]  io_line_pick;                  // Line addressed by per-line registers
    reg  [3:0]  dir_out;                       // One means output
    reg  [3:0]  io_polarity_flip;              // Per-line inverter
    reg  [3:0]  aux_en;                        // 3.3 V supply request per line
    reg         input_filter_kind;             // 0 deglitch, 1 debounce
    reg  [3:0]  output_drive_pick [0:3];       // Source code per line
    reg  [15:0] span_dg [0:3];                 // Deglitch width, us
    reg  [15:0] span_db [0:3];                 // Debounce width, us
    reg  [1:0]  soft_out_bit_pick;             // User bit addressed by value register
    reg  [3:0]  soft_out_packed;               // User output bits

    // Line capabilities
    wire [3:0]  can_out = 4'h6;                // Line 0 and 3 input only
    wire [3:0]  can_aux = 4'h4;                // Only line 2 carries the supply

    // Filter chain results
    wire [3:0]  filt;                          // After deglitch then debounce
    wire [3:0]  levels = filt ^ io_polarity_flip;

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    wire        acc = psel & penable & ~pready;
    wire        wr  = acc & pwrite;
    // Byte lanes below the word are ignored; unaligned offsets alias the word
    wire [11:0] a   = {paddr[11:2], 2'h0};
    wire [1:0]  p   = io_line_pick;

    // Circuit type of the picked line
    // Line 2 reports open drain only while it is set to drive
    reg  [2:0]  io_circuit_type;
    always @* begin
        case (p)
            2'h0:    io_circuit_type = `CGL_FMT_OPTO;
            2'h1:    io_circuit_type = `CGL_FMT_OPTO;
            2'h2:    io_circuit_type = dir_out[2] ? `CGL_FMT_OPENDRAIN : `CGL_FMT_TRISTATE;
            default: io_circuit_type = `CGL_FMT_TRISTATE;
        endcase
    end

    // Known offset check
    reg         hit;
    always @* begin
        case (a)
            `CGL_OFF_PICK, `CGL_OFF_LINE_CFG, `CGL_OFF_SPAN, `CGL_OFF_LEVEL,
            `CGL_OFF_LEVELS, `CGL_OFF_SOFT_PICK, `CGL_OFF_SOFT_VALUE,
            `CGL_OFF_SOFT_PACKED, `CGL_OFF_CIRCUIT: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // Read mux
    reg  [31:0] rd;
    always @* begin
        rd = 32'h0;
        case (a)
            `CGL_OFF_PICK:        rd[1:0] = p;
            `CGL_OFF_LINE_CFG: begin
                rd[`CGL_CFG_DIR]  = dir_out[p];
                rd[`CGL_CFG_FLIP] = io_polarity_flip[p];
                rd[`CGL_CFG_AUX]  = aux_en[p];
                rd[`CGL_CFG_KIND] = input_filter_kind;
                rd[`CGL_CFG_SRC_HI:`CGL_CFG_SRC_LO] = output_drive_pick[p];
            end
            `CGL_OFF_SPAN:        rd[15:0] = input_filter_kind ? span_db[p] : span_dg[p];
            `CGL_OFF_LEVEL:       rd[0] = levels[p];
            `CGL_OFF_LEVELS:      rd[3:0] = levels;
            `CGL_OFF_SOFT_PICK:   rd[1:0] = soft_out_bit_pick;
            `CGL_OFF_SOFT_VALUE:  rd[0] = soft_out_packed[soft_out_bit_pick];
            `CGL_OFF_SOFT_PACKED: rd[3:0] = soft_out_packed;
            `CGL_OFF_CIRCUIT:     rd[2:0] = io_circuit_type;
            default:              rd = 32'h0;
        endcase
    end

    // ----------------------------------------
    // Register writes and bus answer
    // ----------------------------------------
    // One wait state: pready rises the cycle after the access phase starts
    integer i;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_line_pick      <= 2'h0;
            dir_out           <= 4'h0;
            io_polarity_flip  <= 4'h0;
            aux_en            <= 4'h0;
            input_filter_kind <= 1'b0;
            soft_out_bit_pick <= 2'h0;
            soft_out_packed   <= 4'h0;
            prdata            <= 32'h0;
            pready            <= 1'b0;
            pslverr           <= 1'b0;
            for (i = 0; i < 4; i = i + 1) begin
                output_drive_pick[i] <= `CGL_SRC_OFF;
                span_dg[i]           <= 16'h0;
                span_db[i]           <= 16'h0;
            end
        end else begin
            // One-cycle pulse; the ~pready term in acc stops a second take
            pready  <= acc;
            pslverr <= acc & ~hit;
            prdata  <= (acc & ~pwrite) ? rd : 32'h0;
            if (wr) begin
                case (a)
                    `CGL_OFF_PICK: io_line_pick <= pwdata[1:0];
                    `CGL_OFF_LINE_CFG: begin
                        dir_out[p]          <= pwdata[`CGL_CFG_DIR] & can_out[p];
                        io_polarity_flip[p] <= pwdata[`CGL_CFG_FLIP];
                        aux_en[p]           <= pwdata[`CGL_CFG_AUX] & can_aux[p];
                        input_filter_kind   <= pwdata[`CGL_CFG_KIND];
                        output_drive_pick[p] <= pwdata[`CGL_CFG_SRC_HI:`CGL_CFG_SRC_LO];
                    end
                    `CGL_OFF_SPAN: begin
                        if (input_filter_kind)
                            span_db[p] <= pwdata[15:0];
                        else
                            span_dg[p] <= pwdata[15:0];
                    end
                    `CGL_OFF_SOFT_PICK:   soft_out_bit_pick <= pwdata[1:0];
                    `CGL_OFF_SOFT_VALUE:
                        soft_out_packed[soft_out_bit_pick] <= pwdata[0];
                    `CGL_OFF_SOFT_PACKED: soft_out_packed <= pwdata[3:0];
                    default: ;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Per-line filters and drivers
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : ln
            // Widths in cycles; a zero width passes the signal straight on
            // The largest width times the cycles per microsecond still fits 24 bits
            wire [23:0] dg_lim = span_dg[g] * `CGL_CLK_MHZ;
            wire [23:0] db_lim = span_db[g] * `CGL_CLK_MHZ;
            reg  [23:0] dg_cnt;
            reg  [23:0] db_cnt;
            reg         dg_q;
            reg         db_q;
            reg         db_hold;

            // Deglitch: raw must differ for the full width before it is taken
            // A narrower width written mid-count takes effect at once through >=
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    dg_cnt <= 24'h0;
                    dg_q   <= 1'b0;
                end else if (line_in[g] == dg_q) begin
                    dg_cnt <= 24'h0;
                end else if (dg_cnt + 24'h1 >= dg_lim) begin
                    dg_q   <= line_in[g];
                    dg_cnt <= 24'h0;
                end else begin
                    dg_cnt <= dg_cnt + 24'h1;
                end
            end

            // Debounce fed by deglitch: first edge passes, then a lockout
            // The lockout starts only on a passed edge, so chatter cannot stretch it
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    db_q    <= 1'b0;
                    db_cnt  <= 24'h0;
                    db_hold <= 1'b0;
                end else if (db_hold) begin
                    if (db_cnt + 24'h1 >= db_lim) begin
                        db_hold <= 1'b0;
                        db_cnt  <= 24'h0;
                    end else begin
                        db_cnt <= db_cnt + 24'h1;
                    end
                end else if (dg_q != db_q) begin
                    db_q    <= dg_q;
                    db_hold <= (db_lim != 24'h0);
                    db_cnt  <= 24'h0;
                end
            end
            assign filt[g] = db_q;

            // Source multiplexer
            // Line and user codes use the low two bits minus one; code 4 wraps to 3
            reg src;
            always @* begin
                case (output_drive_pick[g])
                    4'h1, 4'h2, 4'h3, 4'h4:
                        src = levels[output_drive_pick[g][1:0] - 2'h1];
                    4'h5, 4'h6, 4'h7, 4'h8:
                        src = soft_out_packed[output_drive_pick[g][1:0] - 2'h1];
                    `CGL_SRC_CNT0: src = counter_active[0];
                    `CGL_SRC_CNT1: src = counter_active[1];
                    `CGL_SRC_LB0:  src = logic_block[0];
                    `CGL_SRC_LB1:  src = logic_block[1];
                    `CGL_SRC_EXPO: src = exposure_active;
                    `CGL_SRC_FTW:  src = frame_trigger_wait;
                    default:       src = 1'b0;
                endcase
            end

            // Pin driver; input lines ignore the source entirely
            // Data is held low on inputs so nothing stale shows when re-enabled
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    line_out[g] <= 1'b0;
                    line_oe[g]  <= 1'b0;
                end else begin
                    line_oe[g]  <= dir_out[g];
                    line_out[g] <= dir_out[g] & (src ^ io_polarity_flip[g]);
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Supply and level outputs
    // ----------------------------------------
    // The rail itself is slow; software must allow settling after a change
    // Only line 2 has the rail; other lines keep their enable bit at zero
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_supply_on <= 1'b0;
            line_level    <= 4'h0;
        end else begin
            aux_supply_on <= aux_en[2];
            line_level    <= levels;
        end
    end

endmodule // cgl_gpio
`default_nettype wire
